/* File: verilog/iraw_pkg.sv */
// Purpose: shared constants, types and pointer wrap decode for the register access pair
// Assumes: one clock MCLK at 100 MHz, asynchronous active-high RESET
// Notes: the device bus address is an arbitrary neutral value
package iraw_pkg;
	// device bus address (value is arbitrary)
	localparam logic [6:0] DEV_ADDR = 7'h2a;
	localparam logic [7:0] PTR_RST = 8'h00; // pointer after reset
	localparam logic [3:0] BIT_LAST = 4'h8; // bits per byte before the ack slot
	// sensor data map
	localparam logic [7:0] STAT_MIRROR = 8'h61;
	localparam logic [7:0] CH0S0_HI = 8'h63;
	localparam logic [7:0] CH0S1_HI = 8'h65;
	localparam logic [7:0] CH1S0_LO = 8'h72;
	localparam logic [7:0] CH1S0_HI = 8'h73;
	localparam logic [7:0] CH1S1_HI = 8'h75;
	// slot enable bit positions
	localparam int EN_C0S0 = 0;
	localparam int EN_C0S1 = 1;
	localparam int EN_C1S0 = 2;
	localparam int EN_C1S1 = 3;
	// controller register offsets
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_QTR = 8'h08;
	localparam logic [15:0] QTR_RST = 16'h00fa; // quarter bit in MCLK cycles
	localparam logic [15:0] QTR_MIN = 16'h0004; // smallest accepted quarter
	// controller commands
	localparam logic [2:0] CMD_START = 3'h1;
	localparam logic [2:0] CMD_STOP = 3'h2;
	localparam logic [2:0] CMD_WRITE = 3'h3;
	localparam logic [2:0] CMD_READ = 3'h4;
	// device states, gray along the write path
	typedef enum logic [3:0] {
		D_IDLE = 4'h0, D_ADDR = 4'h1, D_AACK = 4'h3, D_PTR = 4'h2, D_PACK = 4'h6,
		D_WR = 4'h7, D_WACK = 4'h5, D_RD = 4'h4, D_RACK = 4'hc
	} iraw_dstate_t;
	// controller states
	typedef enum logic [1:0] {H_IDLE = 2'h0, H_RUN = 2'h1} iraw_hstate_t;

	// next read pointer, folding sensor data back to the status mirror
	function automatic logic [7:0] next_ptr(input logic [7:0] p, input logic [3:0] en);
		logic [7:0] n;
		n = p + 8'h01;
		if (en[EN_C1S1]) begin
			if (p == CH0S1_HI) n = CH1S0_LO;
			else if (p == CH1S1_HI) n = STAT_MIRROR;
		end else if (en[EN_C1S0]) begin
			if (p == CH0S1_HI) n = CH1S0_LO;
			else if (p == CH1S0_HI) n = STAT_MIRROR;
		end else if (en[EN_C0S1]) begin
			if (p == CH0S1_HI) n = STAT_MIRROR;
		end else if (en[EN_C0S0]) begin
			if (p == CH0S0_HI) n = STAT_MIRROR;
		end
		return n;
	endfunction
endpackage

/* File: verilog/iraw_if.sv */
// Purpose: two-wire bus joining controller and device
// Assumes: open-drain lines with pull-ups; an enable pulls the line to the output level
// Notes: only the controller drives the clock line
`timescale 1ns/1ps
interface iraw_if;
	logic m_scl_o; // controller clock level when enabled
	logic m_scl_oe; // controller drives clock line
	logic m_sda_o; // controller data level when enabled
	logic m_sda_oe; // controller drives data line
	logic s_sda_o; // device data level when enabled
	logic s_sda_oe; // device drives data line
	logic scl; // resolved clock line
	logic sda; // resolved data line

	// wired-and with pull-up
	assign scl = ~(m_scl_oe & ~m_scl_o);
	assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

	modport dev(input scl, input sda, output s_sda_o, output s_sda_oe);
	modport host(input scl, input sda, output m_scl_o, output m_scl_oe,
		output m_sda_o, output m_sda_oe);
endinterface

/* File: verilog/iraw_sync.sv */
// Purpose: two-stage synchroniser for bus pins
// Assumes: inputs asynchronous to clk
// Notes: only the second stage is visible outside
`timescale 1ns/1ps
module iraw_sync #(
	parameter int W = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pins in, synchronised out
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q; // first stage, read only by second stage

	// each bit passes two flops; lines idle high
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= '1;
			dout <= '1;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule

/* File: verilog/iraw_dev.sv */
// Purpose: device end, two-wire slave with auto-incrementing register pointer
// Assumes: REG_RDATA follows REG_ADDR combinationally on the same clock; SLOT_EN on MCLK
// Notes: never stretches the clock; events seen through synchronised, oversampled lines
// Behaviour
// - write begins START, address, write bit, ack
// - register address byte follows, acknowledged
// - data byte stored, acknowledged, STOP ends
// - pointer advances after each written byte
// - read uses address phase then repeated START
// - read address after repeated START, acknowledged
// - first read byte from stored pointer
// - master ack advances pointer, next byte sent
// - master nack ends read, device releases
// - slot enables choose wrap to status mirror
// - no slots enabled, pointer rolls over
// - ch0 slot0 only, wrap after its high
// - ch0 slot1, wrap after its high byte
// - ch1 slot0, jump then wrap after it
// - ch1 slot1, jump then wrap after it
// - no clock stretching, all within ack
// - bytes MSB first, ninth clock acknowledges
`timescale 1ns/1ps
module iraw_dev #(
	parameter logic [6:0] OWN_ADDR = iraw_pkg::DEV_ADDR
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic RESET,
	// two-wire bus
	iraw_if.dev BUS,
	// register file side
	input wire logic [3:0] SLOT_EN,
	input wire logic [7:0] REG_RDATA,
	output logic [7:0] REG_ADDR,
	output logic [7:0] REG_WDATA,
	output logic REG_WE
);
	import iraw_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// line sampling and bus events
	logic [1:0] lines_s; // synchronised {scl, sda}
	logic scl_s; // synchronised clock line
	logic sda_s; // synchronised data line
	logic scl_p_q; // clock line one cycle earlier
	logic sda_p_q; // data line one cycle earlier
	logic ev_start; // data falls while clock high
	logic ev_stop; // data rises while clock high
	logic ev_rise; // clock rising edge
	logic ev_fall; // clock falling edge

	iraw_sync #(.W(2)) u_sync (
		.clk(MCLK),
		.rst(RESET),
		.din({BUS.scl, BUS.sda}),
		.dout(lines_s)
	);

	assign scl_s = lines_s[1];
	assign sda_s = lines_s[0];
	assign ev_start = scl_p_q & scl_s & sda_p_q & ~sda_s;
	assign ev_stop = scl_p_q & scl_s & ~sda_p_q & sda_s;
	assign ev_rise = ~scl_p_q & scl_s;
	assign ev_fall = scl_p_q & ~scl_s;

	// delayed copies for edge detection
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// transfer state machine
	iraw_dstate_t st_q, st_d; // protocol state
	logic [3:0] cnt_q, cnt_d; // bits done in current byte
	logic [7:0] sh_q, sh_d; // receive or transmit shifter
	logic [7:0] ptr_q, ptr_d; // register pointer
	logic rd_q, rd_d; // address byte asked for read
	logic oe_q, oe_d; // device pulls data line low
	logic we_q, we_d; // register write strobe
	logic [7:0] wdata_q, wdata_d; // register write data
	logic inc_q, inc_d; // pointer step pending after write

	// next state and outputs
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		rd_d = rd_q;
		oe_d = oe_q;
		wdata_d = wdata_q;
		we_d = 1'b0;
		inc_d = 1'b0;
		// step pointer once the write strobe has been seen
		if (inc_q) ptr_d = ptr_q + 8'h01;
		if (ev_start) begin
			// start and repeated start alike; pointer untouched
			st_d = D_ADDR;
			cnt_d = 4'h0;
			oe_d = 1'b0;
		end else if (ev_stop) begin
			// bus free
			st_d = D_IDLE;
			oe_d = 1'b0;
		end else begin
			case (st_q)
				D_ADDR, D_PTR, D_WR: begin
					if (ev_rise) begin
						// sample bit, msb first
						sh_d = {sh_q[6:0], sda_s};
						cnt_d = cnt_q + 4'h1;
					end else if (ev_fall && cnt_q == BIT_LAST) begin
						cnt_d = 4'h0;
						case (st_q)
							D_ADDR: begin
								if (sh_q[7:1] == OWN_ADDR) begin
									// own address: ack in ninth clock
									st_d = D_AACK;
									rd_d = sh_q[0];
									oe_d = 1'b1;
								end else begin
									// foreign address: stay released
									st_d = D_IDLE;
								end
							end
							D_PTR: begin
								// register address byte loads pointer
								ptr_d = sh_q;
								st_d = D_PACK;
								oe_d = 1'b1;
							end
							default: begin
								// data byte stored at pointer
								we_d = 1'b1;
								wdata_d = sh_q;
								inc_d = 1'b1;
								st_d = D_WACK;
								oe_d = 1'b1;
							end
						endcase
					end
				end
				D_AACK: begin
					if (ev_fall) begin
						if (rd_q) begin
							// first read byte from pointer
							sh_d = REG_RDATA;
							oe_d = ~REG_RDATA[7];
							cnt_d = 4'h1;
							st_d = D_RD;
						end else begin
							// release and wait for register address
							oe_d = 1'b0;
							st_d = D_PTR;
						end
					end
				end
				D_PACK, D_WACK: begin
					// release after ack; further bytes are data
					if (ev_fall) begin
						oe_d = 1'b0;
						st_d = D_WR;
					end
				end
				D_RD: begin
					if (ev_fall) begin
						if (cnt_q == BIT_LAST) begin
							// release for master ack
							oe_d = 1'b0;
							st_d = D_RACK;
						end else begin
							// next bit, msb first
							oe_d = ~sh_q[6];
							sh_d = {sh_q[6:0], 1'b0};
							cnt_d = cnt_q + 4'h1;
						end
					end
				end
				D_RACK: begin
					if (ev_rise) begin
						if (sda_s) begin
							// not acknowledged: stop driving
							st_d = D_IDLE;
						end else begin
							// acknowledged: step with wrap
							ptr_d = next_ptr(ptr_q, SLOT_EN);
						end
					end else if (ev_fall) begin
						// send byte at new pointer
						sh_d = REG_RDATA;
						oe_d = ~REG_RDATA[7];
						cnt_d = 4'h1;
						st_d = D_RD;
					end
				end
				default: begin
					// idle: wait for start
					st_d = D_IDLE;
				end
			endcase
		end
	end

	// state registers
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			st_q <= D_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= PTR_RST;
			rd_q <= 1'b0;
			oe_q <= 1'b0;
			we_q <= 1'b0;
			wdata_q <= 8'h00;
			inc_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			ptr_q <= ptr_d;
			rd_q <= rd_d;
			oe_q <= oe_d;
			we_q <= we_d;
			wdata_q <= wdata_d;
			inc_q <= inc_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign BUS.s_sda_o = 1'b0;
	assign BUS.s_sda_oe = oe_q;
	assign REG_ADDR = ptr_q;
	assign REG_WDATA = wdata_q;
	assign REG_WE = we_q;
endmodule

/* File: verilog/iraw_host.sv */
// Purpose: controller end, bus master driven by commands over AHB-Lite
// Assumes: single word transfers; zero wait state slave
// Notes: each bit is four quarters of QTR cycles; clock line never read back
`timescale 1ns/1ps
module iraw_host (
	// clock and reset
	input wire logic MCLK,
	input wire logic RESET,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// two-wire bus
	iraw_if.host BUS
);
	import iraw_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// bus slave and command engine
	logic sda_s; // synchronised data line
	logic ap_ok; // valid address phase
	iraw_hstate_t st_q, st_d; // engine state
	logic ap_wr_q, ap_wr_d; // write data phase pending
	logic [7:0] ap_ad_q, ap_ad_d; // latched offset
	logic [31:0] rd_q, rd_d; // read data
	logic [15:0] qtr_q, qtr_d; // quarter length
	logic [15:0] qc_q, qc_d; // quarter counter
	logic [1:0] ph_q, ph_d; // quarter within bit
	logic [3:0] bit_q, bit_d; // bit within byte
	logic [2:0] op_q, op_d; // current command
	logic [7:0] tx_q, tx_d; // transmit shifter
	logic nk_tx_q, nk_tx_d; // answer read with nack
	logic [7:0] rx_q, rx_d; // received byte
	logic nk_rx_q, nk_rx_d; // ack slot seen high
	logic scl_q, scl_d; // pull clock low
	logic sda_q, sda_d; // pull data low
	logic enter; // a new quarter begins
	logic is_byte; // command moves a byte

	iraw_sync #(.W(1)) u_sync (
		.clk(MCLK),
		.rst(RESET),
		.din(BUS.sda),
		.dout(sda_s)
	);

	assign ap_ok = HSEL & HTRANS[1] & HREADY;
	assign is_byte = (op_q == CMD_WRITE) || (op_q == CMD_READ);

	// next values of bus slave and engine
	always_comb begin
		st_d = st_q;
		ap_wr_d = ap_ok & HWRITE;
		ap_ad_d = ap_ok ? HADDR[7:0] : ap_ad_q;
		rd_d = 32'h0000_0000;
		qtr_d = qtr_q;
		qc_d = qc_q;
		ph_d = ph_q;
		bit_d = bit_q;
		op_d = op_q;
		tx_d = tx_q;
		nk_tx_d = nk_tx_q;
		rx_d = rx_q;
		nk_rx_d = nk_rx_q;
		scl_d = scl_q;
		sda_d = sda_q;
		enter = 1'b0;
		// read data for the next data phase; unmapped reads zero
		if (ap_ok && !HWRITE) begin
			case (HADDR[7:0])
				OFS_STAT: rd_d = {16'h0000, rx_q, 6'h00, nk_rx_q, st_q == H_RUN};
				OFS_QTR: rd_d = {16'h0000, qtr_q};
				default: rd_d = 32'h0000_0000;
			endcase
		end
		// register writes in data phase; commands ignored while busy
		if (ap_wr_q) begin
			case (ap_ad_q)
				OFS_CMD: begin
					if (st_q == H_IDLE && HWDATA[2:0] >= CMD_START && HWDATA[2:0] <= CMD_READ) begin
						st_d = H_RUN;
						op_d = HWDATA[2:0];
						tx_d = HWDATA[15:8];
						nk_tx_d = HWDATA[16];
						qc_d = 16'h0000;
						ph_d = 2'h0;
						bit_d = 4'h0;
						enter = 1'b1;
					end
				end
				OFS_QTR: qtr_d = (HWDATA[15:0] < QTR_MIN) ? QTR_MIN : HWDATA[15:0];
				default: qtr_d = qtr_q;
			endcase
		end
		// quarter timing
		if (st_q == H_RUN) begin
			if (qc_q >= qtr_q - 16'h0001) begin
				qc_d = 16'h0000;
				if (ph_q == 2'h2 && is_byte) begin
					// sample while clock high
					if (bit_q == BIT_LAST) nk_rx_d = sda_s;
					else rx_d = {rx_q[6:0], sda_s};
				end
				if (ph_q != 2'h3) begin
					ph_d = ph_q + 2'h1;
					enter = 1'b1;
				end else if (is_byte && bit_q != BIT_LAST) begin
					ph_d = 2'h0;
					bit_d = bit_q + 4'h1;
					tx_d = {tx_q[6:0], 1'b0};
					enter = 1'b1;
				end else begin
					st_d = H_IDLE;
				end
			end else begin
				qc_d = qc_q + 16'h0001;
			end
		end
		// line levels on entry to a quarter
		if (enter) begin
			case (ph_d)
				2'h0: begin
					if (op_d == CMD_START) sda_d = 1'b0;
					else if (op_d == CMD_STOP) sda_d = 1'b1;
					else if (op_d == CMD_WRITE) sda_d = (bit_d == BIT_LAST) ? 1'b0 : ~tx_d[7];
					else sda_d = (bit_d == BIT_LAST) ? ~nk_tx_d : 1'b0;
				end
				2'h1: scl_d = 1'b0;
				2'h2: begin
					if (op_d == CMD_START) sda_d = 1'b1;
					else if (op_d == CMD_STOP) sda_d = 1'b0;
				end
				default: begin
					if (op_d != CMD_STOP) scl_d = 1'b1;
				end
			endcase
		end
	end

	// registers
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			st_q <= H_IDLE;
			ap_wr_q <= 1'b0;
			ap_ad_q <= 8'h00;
			rd_q <= 32'h0000_0000;
			qtr_q <= QTR_RST;
			qc_q <= 16'h0000;
			ph_q <= 2'h0;
			bit_q <= 4'h0;
			op_q <= 3'h0;
			tx_q <= 8'h00;
			nk_tx_q <= 1'b0;
			rx_q <= 8'h00;
			nk_rx_q <= 1'b0;
			scl_q <= 1'b0;
			sda_q <= 1'b0;
			HREADYOUT <= 1'b0;
			HRESP <= 1'b0;
		end else begin
			st_q <= st_d;
			ap_wr_q <= ap_wr_d;
			ap_ad_q <= ap_ad_d;
			rd_q <= rd_d;
			qtr_q <= qtr_d;
			qc_q <= qc_d;
			ph_q <= ph_d;
			bit_q <= bit_d;
			op_q <= op_d;
			tx_q <= tx_d;
			nk_tx_q <= nk_tx_d;
			rx_q <= rx_d;
			nk_rx_q <= nk_rx_d;
			scl_q <= scl_d;
			sda_q <= sda_d;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign HRDATA = rd_q;
	assign BUS.m_scl_o = 1'b0;
	assign BUS.m_scl_oe = scl_q;
	assign BUS.m_sda_o = 1'b0;
	assign BUS.m_sda_oe = sda_q;
endmodule

/* File: verification/iraw_props.sv */
// Purpose: checker for the two-wire link between controller and device
// Assumes: single MCLK domain, RESET asynchronous active high
// Notes: sees only the interface signals, instantiated beside the interface
`timescale 1ns/1ps
module iraw_props (
	// clock and reset
	input wire logic MCLK,
	input wire logic RESET,
	// interface signals
	input wire logic m_scl_o,
	input wire logic m_scl_oe,
	input wire logic m_sda_o,
	input wire logic m_sda_oe,
	input wire logic s_sda_o,
	input wire logic s_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic frame_q, frame_d; // between start and stop
	logic [3:0] falls_q, falls_d; // clock falls while device pulls data
	logic scl_q, sda_q; // line levels one cycle ago
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RESET);
	////////////////////////////////////////////////////////////////////
	// frame tracking and device hold counter
	always_comb begin
		frame_d = frame_q;
		falls_d = falls_q;
		if (scl && scl_q && sda_q && !sda) frame_d = 1'b1;
		if (scl && scl_q && !sda_q && sda) frame_d = 1'b0;
		if (!s_sda_oe) falls_d = 4'h0;
		else if (scl_q && !scl) falls_d = falls_q + 4'h1;
	end
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			frame_q <= 1'b0;
			falls_q <= 4'h0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			frame_q <= frame_d;
			falls_q <= falls_d;
			scl_q <= scl;
			sda_q <= sda;
		end
	end
	////////////////////////////////////////////////////////////////////
	// assertions
	a_scl_only_host:
		assert property (scl == !m_scl_oe) else $error("clock line held by device");
	a_open_drain:
		assert property (!m_scl_o && !m_sda_o && !s_sda_o) else $error("line driven high");
	a_scl_low_min:
		assert property ($fell(scl) |-> !scl [*4]) else $error("clock low too short");
	a_scl_high_min:
		assert property ($rose(scl) |-> scl [*4]) else $error("clock high too short");
	a_dev_edge_low:
		assert property ($changed(s_sda_oe) |-> !scl) else $error("device data moved, clock high");
	a_dev_after_fall:
		assert property ($rose(s_sda_oe) |-> !$past(scl) && !$past(scl, 2))
			else $error("device drove data too soon after clock fall");
	a_dev_in_frame:
		assert property (s_sda_oe |-> frame_q) else $error("device drives outside a frame");
	// address ack can run straight into a first read byte: ack fall plus eight bit falls
	a_dev_hold_max:
		assert property (falls_q <= 4'h9) else $error("device held data line too long");
	// main scenarios
	c_start: cover property (scl && scl_q && $fell(sda));
	c_dev_drive: cover property ($rose(s_sda_oe));
	c_dev_release: cover property ($fell(s_sda_oe) && frame_q);
endmodule

/* File: verification/tb_top.sv */
// Purpose: testbench joining controller and device over the two-wire link
// Assumes: software view over AHB-Lite, byte memory behind the device
// Notes: quarter bit set to 8 clocks to keep the run short
`timescale 1ns/1ps
module tb_top;
	import iraw_pkg::*;
	logic mclk = 1'b0; // 100 MHz clock
	logic reset = 1'b1; // async reset
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [3:0] slot_en = 4'h0; // source slot enables
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_we;
	logic [7:0] mem [256]; // register file behind the device
	int bad_count = 0;
	int checks = 0;
	int we_cnt = 0; // device write strobes seen
	iraw_if bus();
	always #5 mclk = ~mclk;
	////////////////////////////////////////////////////////////////////
	// both ends and checker
	iraw_host i_iraw_host (.MCLK(mclk), .RESET(reset), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .BUS(bus.host));
	iraw_dev i_iraw_dev (.MCLK(mclk), .RESET(reset), .BUS(bus.dev), .SLOT_EN(slot_en),
		.REG_RDATA(mem[reg_addr]), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WE(reg_we));
	iraw_props i_iraw_props (.MCLK(mclk), .RESET(reset), .m_scl_o(bus.m_scl_o),
		.m_scl_oe(bus.m_scl_oe), .m_sda_o(bus.m_sda_o), .m_sda_oe(bus.m_sda_oe),
		.s_sda_o(bus.s_sda_o), .s_sda_oe(bus.s_sda_oe), .scl(bus.scl), .sda(bus.sda));
	// memory write port
	always @(posedge mclk) begin
		if (reg_we === 1'b1) begin
			mem[reg_addr] <= reg_wdata;
			we_cnt++;
		end
	end
	////////////////////////////////////////////////////////////////////
	// helpers
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// wait for hready sampled high at a rising edge
	task automatic hwait();
		int n;
		n = 0;
		@(posedge mclk);
		while (hreadyout !== 1'b1 && n < 64) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 64) begin
			chk("hready wait", 32'h1, 32'h0);
			tally_and_finish();
		end
	endtask
	// one single-word AHB transfer
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		hwait();
		// address taken at this edge; data phase follows at once
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		hwait();
		// read data taken at the edge that ends the data phase
		rd = hrdata;
	endtask
	// issue a command and poll until the engine is idle
	task automatic cmd(input logic [2:0] c, input logic [7:0] b, input logic nack,
		output logic ack, output logic [7:0] rx);
		logic [31:0] st;
		int n;
		ahb(1'b1, OFS_CMD, {15'h0, nack, b, 5'h0, c}, st);
		n = 0;
		st = 32'h1;
		while (st[0] !== 1'b0 && n < 2000) begin
			ahb(1'b0, OFS_STAT, 32'h0, st);
			n++;
		end
		if (n >= 2000) begin
			chk("busy wait", 32'h0, 32'h1);
			tally_and_finish();
		end
		ack = ~st[1];
		rx = st[15:8];
	endtask
	task automatic wb(input logic [7:0] b, input logic ok);
		logic a;
		logic [7:0] r;
		cmd(CMD_WRITE, b, 1'b0, a, r);
		chk("ack", ok, a);
	endtask
	task automatic ev(input logic [2:0] c);
		logic a;
		logic [7:0] r;
		cmd(c, 8'h00, 1'b0, a, r);
	endtask
	// expected read pointer step, from the wrap table
	function automatic logic [7:0] nxt(input logic [7:0] p, input logic [3:0] e);
		if ((e[3] && p == 8'h75) || (e[3:2] == 2'b01 && p == 8'h73) ||
			(e[3:1] == 3'b001 && p == 8'h65) || (e == 4'h1 && p == 8'h63))
			return 8'h61;
		if (e[3:2] != 2'b00 && p == 8'h65)
			return 8'h72;
		return p + 8'h01;
	endfunction
	////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_regs();
		logic [31:0] r;
		ahb(1'b0, OFS_QTR, 32'h0, r);
		chk("qtr reset", {16'h0, QTR_RST}, r);
		ahb(1'b0, OFS_STAT, 32'h0, r);
		chk("stat reset", 32'h0, r);
		chk("hresp", 32'h0, {31'h0, hresp});
		ahb(1'b0, 8'h0c, 32'h0, r);
		chk("unmapped", 32'h0, r);
		ahb(1'b1, OFS_CMD, 32'h5, r);
		ahb(1'b0, OFS_STAT, 32'h0, r);
		chk("bad cmd ignored", 32'h0, r);
		ahb(1'b1, OFS_QTR, 32'h1, r);
		ahb(1'b0, OFS_QTR, 32'h0, r);
		chk("qtr floor", {16'h0, QTR_MIN}, r);
		ahb(1'b1, OFS_QTR, 32'h8, r);
		$display("test regs done");
	endtask
	task automatic t_foreign();
		int w;
		w = we_cnt;
		ev(CMD_START);
		wb({DEV_ADDR ^ 7'h01, 1'b0}, 1'b0);
		wb(8'h20, 1'b0);
		ev(CMD_STOP);
		chk("no write", w, we_cnt);
		$display("test foreign done");
	endtask
	task automatic t_write();
		ev(CMD_START);
		wb({DEV_ADDR, 1'b0}, 1'b1);
		wb(8'hfe, 1'b1);
		wb(8'hc3, 1'b1);
		wb(8'h3c, 1'b1);
		wb(8'h81, 1'b1);
		ev(CMD_STOP);
		chk("mem fe", 8'hc3, mem[8'hfe]);
		chk("mem ff", 8'h3c, mem[8'hff]);
		chk("mem 00", 8'h81, mem[8'h00]);
		$display("test write done");
	endtask
	task automatic t_read(input logic [3:0] en, input logic [7:0] s, input int n);
		logic a;
		logic [7:0] r;
		logic [7:0] p;
		@(posedge mclk);
		slot_en <= en;
		ev(CMD_START);
		wb({DEV_ADDR, 1'b0}, 1'b1);
		wb(s, 1'b1);
		ev(CMD_START);
		wb({DEV_ADDR, 1'b1}, 1'b1);
		p = s;
		for (int i = 0; i < n; i++) begin
			cmd(CMD_READ, 8'hff, i == n - 1, a, r);
			chk("read byte", mem[p], r);
			p = nxt(p, en);
		end
		ev(CMD_STOP);
		$display("test read %h done", en);
	endtask
	////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'ha5;
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		repeat (3) @(posedge mclk);
		t_regs();
		t_foreign();
		t_write();
		t_read(4'h0, 8'hfe, 4);
		t_read(4'h1, 8'h61, 7);
		t_read(4'h2, 8'h61, 7);
		t_read(4'h7, 8'h61, 10);
		t_read(4'hb, 8'h60, 12);
		tally_and_finish();
	end
endmodule
